// file: rtl/mfp_mode_power_ctrl.sv
// operating mode, firmware update and power-off notice control of a managed flash device
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - invalid conditions or CMD15 enter inactive mode; only power cycle leaves it
// - internal reset sequence starts on the filtered rising edge of the reset line
// - pulses shorter than 500 ns (5 core clock cycles) on the reset line are ignored
// - reset line pulses of 1 us or more are recognised
// - writing update value to mode select turns transfers into firmware transfers
// - writing normal value leaves update mode, possibly aborting the download
// - device reports count of correctly programmed sectors for resume
// - without operation codes, firmware installs on next CMD0 or hardware reset
// - notice byte holds supply-live, quick or slow shutdown codes
// - device drives busy on the data line while preparing for shutdown
// - quick shutdown ends within generic timeout, slow within slow limit
// - further commands (except CMD7 and CMD5 during a sleep warning) or interrupt request during busy restore supply-live
// - writing zero after another notice value is rejected with a switch error
// - sleep warning busy lasts no longer than the stored limit
// - leaving sleep or interrupted sleep warning restores supply-live
// - command line open-drain during initialisation, push-pull afterwards
module mfp_mode_power_ctrl
  import mfp_pkg::*;
#(
  parameter int unsigned GEN_TIMEOUT_CYC = GEN_TIMEOUT_MS * CYC_PER_MS,
  parameter int unsigned SLOW_OFF_CYC = SLOW_OFF_MS * CYC_PER_MS,
  parameter int unsigned SLEEP_UNIT = SLEEP_UNIT_CYC,
  parameter logic [7:0] CAPABILITY = 8'h01,
  parameter logic [7:0] FW_SETUP = 8'h00,
  parameter logic [31:0] UPDATE_ARG = 32'h0000c7c7, // arbitrary
  parameter logic [7:0] OPCODES = 8'h00
) (
  // clock and power-on reset
  input wire logic core_clk,
  input wire logic reset,
  // pins
  input wire logic hw_reset_n_pin,
  input wire logic link_clk_pin,
  input wire logic cmd_pin_i,
  output logic dat0_o,
  output logic dat0_oe,
  output logic cmd_od_mode,
  // decoded commands
  input wire logic cmd_valid,
  input wire logic [5:0] cmd_index,
  input wire logic [31:0] cmd_arg,
  input wire logic op_cond_bad,
  input wire logic hpi_req,
  // extended configuration space
  input wire logic sw_valid,
  input wire logic [8:0] sw_index,
  input wire logic [7:0] sw_value,
  output logic sw_error,
  input wire logic [8:0] ext_rd_index,
  output logic [7:0] ext_rd_data,
  // back end
  input wire logic sector_ok,
  input wire logic prep_done,
  // status
  output mfp_pkg::mfp_mode_t mode_state,
  output logic fw_transfer,
  output logic int_reset_p,
  output logic fw_install_p,
  output logic init_clocks_ok,
  output logic busy
);
  import mfp_pkg::*;

  logic rst_clean;
  logic rst_rise;
  logic lclk_meta_r;
  logic lclk_sync_r;
  logic lclk_prev_r;
  logic cmdl_meta_r;
  logic cmdl_sync_r;
  logic [6:0] clk_count_r;
  logic [7:0] notice_r;
  logic [7:0] mode_sel_r;
  logic [7:0] sleep_limit_r;
  logic [31:0] sectors_r;
  logic install_pend_r;
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_lim_r;
  logic go_idle;
  logic reset_ev;
  logic notice_wr;
  logic notice_ok;
  logic mode_wr;
  logic mode_ok;
  logic busy_end;
  logic cmd_restore;
  logic wake;
  logic [31:0] sleep_lim;

  function automatic logic is_cmd(input logic [5:0] idx);
    is_cmd = cmd_valid && cmd_index == idx;
  endfunction : is_cmd

  // ----------------------------------------------------------------
  // reset pin, link clock and command line sampling
  // ----------------------------------------------------------------
  mfp_reset_filter #(
    .STABLE(RST_FILT_CYC)
  ) u_rst_filt (
    .core_clk(core_clk),
    .reset(reset),
    .line_raw(hw_reset_n_pin),
    .line_clean(rst_clean),
    .rise_p(rst_rise)
  );

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lclk_meta_r <= 1'b0;
      lclk_sync_r <= 1'b0;
      lclk_prev_r <= 1'b0;
      cmdl_meta_r <= 1'b1;
      cmdl_sync_r <= 1'b1;
    end else begin
      lclk_meta_r <= link_clk_pin;
      lclk_sync_r <= lclk_meta_r;
      lclk_prev_r <= lclk_sync_r;
      cmdl_meta_r <= cmd_pin_i;
      cmdl_sync_r <= cmdl_meta_r;
    end
  end

  // count link clocks after reset; status only, the device does not refuse early commands
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      clk_count_r <= 7'h00;
    end else if (reset_ev) begin
      clk_count_r <= 7'h00;
    end else if (lclk_sync_r && !lclk_prev_r && clk_count_r != INIT_CLOCKS) begin
      clk_count_r <= clk_count_r + 7'h01;
    end
  end
  assign init_clocks_ok = clk_count_r == INIT_CLOCKS;

  // ----------------------------------------------------------------
  // reset events
  // ----------------------------------------------------------------
  // inactive ignores hardware reset and CMD0 alike
  assign go_idle = is_cmd(CMD_GO_IDLE) && mode_state != MFP_INACTIVE;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      int_reset_p <= 1'b0;
    end else begin
      int_reset_p <= rst_rise && mode_state != MFP_INACTIVE;
    end
  end
  assign reset_ev = int_reset_p || go_idle;

  // ----------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------
  assign wake = is_cmd(CMD_SLEEP_AWAKE) && !cmd_arg[SLEEP_ARG_BIT] && mode_state == MFP_SLEEP;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode_state <= MFP_PRE_IDLE;
    end else if (mode_state == MFP_INACTIVE) begin
      mode_state <= MFP_INACTIVE;
    end else if (op_cond_bad || is_cmd(CMD_GO_INACTIVE)) begin
      mode_state <= MFP_INACTIVE;
    end else if (int_reset_p) begin
      mode_state <= MFP_PRE_IDLE;
    end else if (go_idle) begin
      mode_state <= (cmd_arg == BOOT_ARG) ? MFP_BOOT : MFP_PRE_IDLE;
    end else begin
      unique case (mode_state)
        MFP_PRE_IDLE: begin
          if (!cmdl_sync_r) begin
            mode_state <= MFP_BOOT;
          end else if (is_cmd(CMD_SEND_OP)) begin
            mode_state <= MFP_ACTIVE;
          end
        end
        MFP_BOOT: begin
          if (is_cmd(CMD_SEND_OP)) begin
            mode_state <= MFP_ACTIVE;
          end
        end
        MFP_ACTIVE: begin
          if (is_cmd(CMD_SLEEP_AWAKE) && cmd_arg[SLEEP_ARG_BIT] && !busy &&
              (notice_r == NOTICE_LIVE || notice_r == NOTICE_SLEEP)) begin
            mode_state <= MFP_SLEEP;
          end
        end
        MFP_SLEEP: begin
          if (wake) begin
            mode_state <= MFP_ACTIVE;
          end
        end
        MFP_INACTIVE: begin
          mode_state <= MFP_INACTIVE;
        end
      endcase
    end
  end

  // open-drain while the bus is still being identified
  assign cmd_od_mode = mode_state == MFP_PRE_IDLE || mode_state == MFP_BOOT;

  // ----------------------------------------------------------------
  // switch writes
  // ----------------------------------------------------------------
  assign notice_wr = sw_valid && sw_index == EXT_POWER_OFF_NOTICE;
  assign notice_ok = notice_wr && sw_value <= NOTICE_SLEEP &&
                     !(sw_value == NOTICE_NONE && notice_r != NOTICE_NONE);
  assign mode_wr = sw_valid && sw_index == EXT_MODE_SELECT;
  assign mode_ok = mode_wr && (sw_value == MODE_NORMAL || sw_value == MODE_UPDATE);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sw_error <= 1'b0;
    end else begin
      sw_error <= (notice_wr && !notice_ok) || (mode_wr && !mode_ok) ||
                  (sw_valid && sw_index >= EXT_RO_BASE);
    end
  end

  // ----------------------------------------------------------------
  // field update
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode_sel_r <= MODE_NORMAL;
    end else if (reset_ev) begin
      mode_sel_r <= MODE_NORMAL;
    end else if (mode_ok) begin
      mode_sel_r <= sw_value;
    end
  end
  assign fw_transfer = mode_sel_r == MODE_UPDATE;

  // the count survives leaving update mode so that the host can resume
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sectors_r <= 32'h0000_0000;
    end else if (fw_install_p) begin
      sectors_r <= 32'h0000_0000;
    end else if (sector_ok && fw_transfer) begin
      sectors_r <= sectors_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      install_pend_r <= 1'b0;
      fw_install_p <= 1'b0;
    end else begin
      fw_install_p <= install_pend_r && reset_ev;
      if (install_pend_r && reset_ev) begin
        install_pend_r <= 1'b0;
      end else if (OPCODES == 8'h00 && fw_transfer && mode_ok && sw_value == MODE_NORMAL &&
                   sectors_r != 32'h0000_0000) begin
        install_pend_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // power-off notice and busy
  // ----------------------------------------------------------------
  // commands that are part of the sleep path do not cancel a sleep warning
  assign cmd_restore = cmd_valid && !sw_valid &&
                       (notice_r == NOTICE_QUICK || notice_r == NOTICE_SLOW ||
                        notice_r == NOTICE_SLEEP) &&
                       !(notice_r == NOTICE_SLEEP &&
                         (cmd_index == CMD_SELECT || cmd_index == CMD_SLEEP_AWAKE));

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      notice_r <= NOTICE_NONE;
    end else if (notice_ok) begin
      notice_r <= sw_value;
    end else if (cmd_restore || (busy && hpi_req)) begin
      notice_r <= NOTICE_LIVE;
    end else if (wake) begin
      notice_r <= NOTICE_LIVE;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sleep_limit_r <= SLEEP_LIMIT_RST;
    end else begin
      sleep_limit_r <= sleep_limit_r;
    end
  end

  // a zero limit still gives one cycle of busy
  assign sleep_lim = (sleep_limit_r == 8'h00) ? 32'h0000_0001 :
                     32'(sleep_limit_r) * 32'(SLEEP_UNIT);
  // forced release at the limit keeps the bound even if the back end stalls
  assign busy_end = prep_done || busy_cnt_r == busy_lim_r - 32'h0000_0001;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      busy_cnt_r <= 32'h0000_0000;
      busy_lim_r <= 32'h0000_0001;
    end else if (notice_ok && sw_value >= NOTICE_QUICK) begin
      busy <= 1'b1;
      busy_cnt_r <= 32'h0000_0000;
      unique case (sw_value)
        NOTICE_QUICK: busy_lim_r <= 32'(GEN_TIMEOUT_CYC);
        NOTICE_SLOW: busy_lim_r <= 32'(SLOW_OFF_CYC);
        default: busy_lim_r <= sleep_lim;
      endcase
    end else if (busy && (busy_end || hpi_req || cmd_restore)) begin
      busy <= 1'b0;
    end else if (busy) begin
      busy_cnt_r <= busy_cnt_r + 32'h0000_0001;
    end
  end

  assign dat0_o = 1'b0;
  assign dat0_oe = busy;

  // ----------------------------------------------------------------
  // extended configuration space read
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ext_rd_data <= 8'h00;
    end else begin
      ext_rd_data <= 8'h00;
      if (ext_rd_index == EXT_POWER_OFF_NOTICE) ext_rd_data <= notice_r;
      if (ext_rd_index == EXT_SLEEP_WARN_LIMIT) ext_rd_data <= sleep_limit_r;
      if (ext_rd_index == EXT_MODE_SELECT) ext_rd_data <= mode_sel_r;
      if (ext_rd_index == EXT_CAPABILITY) ext_rd_data <= CAPABILITY;
      if (ext_rd_index == EXT_FW_SETUP) ext_rd_data <= FW_SETUP;
      if (ext_rd_index == EXT_OPCODE) ext_rd_data <= OPCODES;
      if (ext_rd_index[8:2] == EXT_FW_SECTORS[8:2]) begin
        ext_rd_data <= mfp_pick_byte(sectors_r, ext_rd_index[1:0]);
      end
      if (ext_rd_index >= EXT_UPDATE_ARG && ext_rd_index < EXT_OPCODE) begin
        ext_rd_data <= mfp_pick_byte(UPDATE_ARG, 2'(ext_rd_index - EXT_UPDATE_ARG));
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  inactive_sticky_a: assert property (@(posedge core_clk) disable iff (reset)
    mode_state == MFP_INACTIVE |=> mode_state == MFP_INACTIVE [*3])
    else $error("inactive mode left without power cycle");

  inactive_entry_a: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && cmd_index == CMD_GO_INACTIVE |=> mode_state == MFP_INACTIVE)
    else $error("CMD15 did not enter inactive mode");

  reset_seq_a: assert property (@(posedge core_clk) disable iff (reset)
    int_reset_p |-> $past(rst_rise) ##1 (mode_state == MFP_PRE_IDLE || mode_state == MFP_INACTIVE))
    else $error("reset sequence not tied to filtered rising edge");

  update_mode_a: assert property (@(posedge core_clk) disable iff (reset)
    mode_ok && sw_value == MODE_UPDATE && !reset_ev |=> fw_transfer)
    else $error("update mode not entered");

  sector_count_a: assert property (@(posedge core_clk) disable iff (reset)
    sector_ok && fw_transfer && !fw_install_p |=> sectors_r == $past(sectors_r) + 32'h0000_0001)
    else $error("sector count did not step");

  install_event_a: assert property (@(posedge core_clk) disable iff (reset)
    install_pend_r && reset_ev |=> fw_install_p ##1 !install_pend_r)
    else $error("firmware not installed on reset event");

  busy_pin_a: assert property (@(posedge core_clk) disable iff (reset)
    notice_ok && sw_value >= NOTICE_QUICK |=> busy && dat0_oe && !dat0_o)
    else $error("shutdown code did not drive busy");

  busy_bound_a: assert property (@(posedge core_clk) disable iff (reset)
    busy |-> busy_cnt_r < busy_lim_r)
    else $error("busy ran past its limit");

  hpi_restore_a: assert property (@(posedge core_clk) disable iff (reset)
    busy && hpi_req && !notice_ok |=> !busy && notice_r == NOTICE_LIVE)
    else $error("interrupt request did not restore supply-live");

  zero_reject_a: assert property (@(posedge core_clk) disable iff (reset)
    notice_wr && sw_value == NOTICE_NONE && notice_r != NOTICE_NONE
    |=> sw_error && notice_r != NOTICE_NONE)
    else $error("zero notice write not rejected");

  wake_live_a: assert property (@(posedge core_clk) disable iff (reset)
    wake && !notice_ok && !op_cond_bad && !int_reset_p
    |=> notice_r == NOTICE_LIVE && mode_state == MFP_ACTIVE)
    else $error("wake did not restore supply-live");

  boot_entry_c: cover property (@(posedge core_clk) disable iff (reset)
    mode_state == MFP_PRE_IDLE ##1 mode_state == MFP_BOOT);
  sleep_entry_c: cover property (@(posedge core_clk) disable iff (reset)
    notice_r == NOTICE_SLEEP ##[1:50] mode_state == MFP_SLEEP);
  install_c: cover property (@(posedge core_clk) disable iff (reset) fw_install_p);
  shutdown_done_c: cover property (@(posedge core_clk) disable iff (reset)
    busy && prep_done ##1 !busy);

endmodule : mfp_mode_power_ctrl

`default_nettype wire

// file: rtl/mfp_pkg.sv
// constants, codes and types for the managed flash mode and power control block
package mfp_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
  localparam int unsigned RST_MIN_US = 1;
  // stable time for the reset filter: half the least pulse, rounded down
  localparam int unsigned RST_FILT_CYC = (RST_MIN_US * 1000 / 2) / CLK_PERIOD_NS;
  localparam int unsigned GEN_TIMEOUT_MS = 10;
  localparam int unsigned SLOW_OFF_MS = 100;
  localparam int unsigned SLEEP_UNIT_US = 10;
  localparam int unsigned SLEEP_UNIT_CYC = SLEEP_UNIT_US * 1000 / CLK_PERIOD_NS;
  localparam logic [6:0] INIT_CLOCKS = 7'h4a;

  // ----------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_GO_IDLE = 6'h00;
  localparam logic [5:0] CMD_SEND_OP = 6'h01;
  localparam logic [5:0] CMD_SLEEP_AWAKE = 6'h05;
  localparam logic [5:0] CMD_SELECT = 6'h07;
  localparam logic [5:0] CMD_GO_INACTIVE = 6'h0f;
  localparam logic [31:0] BOOT_ARG = 32'hfffffffa;
  localparam int unsigned SLEEP_ARG_BIT = 15;

  // ----------------------------------------------------------------
  // extended configuration space indices
  // ----------------------------------------------------------------
  localparam logic [8:0] EXT_POWER_OFF_NOTICE = 9'h022;
  localparam logic [8:0] EXT_SLEEP_WARN_LIMIT = 9'h0d8;
  localparam logic [8:0] EXT_MODE_SELECT = 9'h050;
  localparam logic [8:0] EXT_FW_SECTORS = 9'h100;
  localparam logic [8:0] EXT_CAPABILITY = 9'h104;
  localparam logic [8:0] EXT_FW_SETUP = 9'h105;
  localparam logic [8:0] EXT_UPDATE_ARG = 9'h106;
  localparam logic [8:0] EXT_OPCODE = 9'h10a;
  localparam logic [8:0] EXT_RO_BASE = 9'h0c0;

  // ----------------------------------------------------------------
  // field values
  // ----------------------------------------------------------------
  localparam logic [7:0] NOTICE_NONE = 8'h00;
  localparam logic [7:0] NOTICE_LIVE = 8'h01;
  localparam logic [7:0] NOTICE_QUICK = 8'h02;
  localparam logic [7:0] NOTICE_SLOW = 8'h03;
  localparam logic [7:0] NOTICE_SLEEP = 8'h04;
  localparam logic [7:0] MODE_NORMAL = 8'h00;
  localparam logic [7:0] MODE_UPDATE = 8'h01;
  localparam logic [7:0] SLEEP_LIMIT_RST = 8'h0a;

  typedef enum logic [2:0] {
    MFP_PRE_IDLE,
    MFP_BOOT,
    MFP_ACTIVE,
    MFP_SLEEP,
    MFP_INACTIVE
  } mfp_mode_t;

  // byte sel of a little-endian word
  function automatic logic [7:0] mfp_pick_byte(input logic [31:0] word, input logic [1:0] sel);
    mfp_pick_byte = word[{sel, 3'h0} +: 8];
  endfunction : mfp_pick_byte

endpackage : mfp_pkg

// file: rtl/mfp_reset_filter.sv
// synchroniser and noise filter for the hardware reset pin
`timescale 1ns/1ns
`default_nettype none

module mfp_reset_filter #(
  parameter int unsigned STABLE = mfp_pkg::RST_FILT_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // pin side
  input wire logic line_raw,
  // filtered side
  output logic line_clean,
  output logic rise_p
);
  import mfp_pkg::*;

  logic meta_r;
  logic sync_r;
  logic [7:0] stable_cnt_r;

  // ----------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= line_raw;
      sync_r <= meta_r;
    end
  end

  // ----------------------------------------------------------------
  // filter: level must hold for STABLE cycles before it is taken
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stable_cnt_r <= 8'h00;
      line_clean <= 1'b1;
      rise_p <= 1'b0;
    end else begin
      rise_p <= 1'b0;
      if (sync_r == line_clean) begin
        stable_cnt_r <= 8'h00;
      end else if (stable_cnt_r == 8'(STABLE - 1)) begin
        stable_cnt_r <= 8'h00;
        line_clean <= sync_r;
        rise_p <= sync_r;
      end else begin
        stable_cnt_r <= stable_cnt_r + 8'h01;
      end
    end
  end

  glitch_reject_a: assert property (@(posedge core_clk) disable iff (reset)
    $changed(line_clean) |-> $past(sync_r, 1) == line_clean && $past(sync_r, 2) == line_clean)
    else $error("reset line taken without a stable level");

  long_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
    (sync_r != line_clean) [*5] |=> line_clean == $past(sync_r))
    else $error("held reset level not taken in time");

endmodule : mfp_reset_filter

`default_nettype wire

// file: tb/mfp_host_model.sv
// host-side model driving the reset, clock and command pins
`timescale 1ns/1ns
`default_nettype none

module mfp_host_model (
  // pins toward the device
  output logic hw_reset_n_pin,
  output logic link_clk_pin,
  output logic cmd_pin_i
);
  // command line rests high on its pull-up; clock still outside bursts
  initial begin
    hw_reset_n_pin = 1'b1;
    link_clk_pin = 1'b0;
    cmd_pin_i = 1'b1;
  end

  task automatic clocks(input int n);
    repeat (n) begin
      #400 link_clk_pin = 1'b1;
      #400 link_clk_pin = 1'b0;
    end
  endtask : clocks

  // command line held low while the device waits asks for boot
  task automatic cmd_low(input int ns);
    cmd_pin_i = 1'b0;
    #(ns) cmd_pin_i = 1'b1;
  endtask : cmd_low

  // high interval and command gap are kept before returning
  task automatic pulse(input int low_ns);
    hw_reset_n_pin = 1'b0;
    #(low_ns) hw_reset_n_pin = 1'b1;
    #200000;
  endtask : pulse
endmodule : mfp_host_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the mode and power control block
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import mfp_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0, op_cond_bad = 1'b0, hpi_req = 1'b0, sw_valid = 1'b0;
  logic sector_ok = 1'b0, prep_done = 1'b0, seen_rst = 1'b0, seen_ins = 1'b0;
  logic [5:0] cmd_index = 6'h00;
  logic [31:0] cmd_arg = 32'h0;
  logic [8:0] sw_index = 9'h000, ext_rd_index = 9'h000;
  logic [7:0] sw_value = 8'h00;
  logic hw_n, lclk, cmd_ln, dat0, dat0_oe, od, sw_error, fw_tr, int_rst, fw_ins, clk_ok, busy;
  logic [7:0] ext_rd_data;
  mfp_mode_t mode_state;
  int err_total = 0, samples_checked = 0, cyc = 0;

  always #50 core_clk = ~core_clk;

  // pulses are latched so a one-cycle output is never missed
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (int_rst === 1'b1) seen_rst <= 1'b1;
    if (fw_ins === 1'b1) seen_ins <= 1'b1;
    if (cyc == 12000) begin
      err_total++;
      end_of_test();
    end
  end

  mfp_host_model host (.hw_reset_n_pin(hw_n), .link_clk_pin(lclk), .cmd_pin_i(cmd_ln));

  mfp_mode_power_ctrl #(.GEN_TIMEOUT_CYC(20), .SLOW_OFF_CYC(40), .SLEEP_UNIT(2)) dut (
    .core_clk(core_clk), .reset(reset), .hw_reset_n_pin(hw_n), .link_clk_pin(lclk),
    .cmd_pin_i(cmd_ln), .dat0_o(dat0), .dat0_oe(dat0_oe), .cmd_od_mode(od),
    .cmd_valid(cmd_valid), .cmd_index(cmd_index), .cmd_arg(cmd_arg),
    .op_cond_bad(op_cond_bad), .hpi_req(hpi_req), .sw_valid(sw_valid),
    .sw_index(sw_index), .sw_value(sw_value), .sw_error(sw_error),
    .ext_rd_index(ext_rd_index), .ext_rd_data(ext_rd_data), .sector_ok(sector_ok),
    .prep_done(prep_done), .mode_state(mode_state), .fw_transfer(fw_tr),
    .int_reset_p(int_rst), .fw_install_p(fw_ins), .init_clocks_ok(clk_ok), .busy(busy));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic bit1(input logic b, input logic e, input string m);
    chk({7'h00, b}, {7'h00, e}, m);
  endtask : bit1

  task automatic cmd(input logic [5:0] i, input logic [31:0] a, input mfp_mode_t e);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_index <= i;
    cmd_arg <= a;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    @(negedge core_clk);
    chk(8'(mode_state), 8'(e), "mode");
  endtask : cmd

  task automatic sw(input logic [8:0] i, input logic [7:0] v, input logic e);
    @(posedge core_clk);
    sw_valid <= 1'b1;
    sw_index <= i;
    sw_value <= v;
    @(posedge core_clk);
    sw_valid <= 1'b0;
    @(negedge core_clk);
    bit1(sw_error, e, "switch error");
  endtask : sw

  task automatic rd(input logic [8:0] i, input logic [7:0] e);
    @(posedge core_clk);
    ext_rd_index <= i;
    @(posedge core_clk);
    @(negedge core_clk);
    chk(ext_rd_data, e, "read");
  endtask : rd

  // k: 0 prep done, 1 interrupt request, 2 sector ok, 3 bad conditions
  task automatic strobe(input int k);
    @(posedge core_clk);
    prep_done <= k == 0;
    hpi_req <= k == 1;
    sector_ok <= k == 2;
    op_cond_bad <= k == 3;
    @(posedge core_clk);
    prep_done <= 1'b0;
    hpi_req <= 1'b0;
    sector_ok <= 1'b0;
    op_cond_bad <= 1'b0;
    @(negedge core_clk);
  endtask : strobe

  task automatic idle(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    bit1(busy, 1'b0, "busy");
  endtask : idle

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    rd(EXT_POWER_OFF_NOTICE, NOTICE_NONE);
    rd(EXT_SLEEP_WARN_LIMIT, SLEEP_LIMIT_RST);
    host.clocks(74);
    bit1(clk_ok, 1'b1, "clocks");
    cmd(CMD_GO_IDLE, BOOT_ARG, MFP_BOOT);
    bit1(od, 1'b1, "open drain");
    cmd(CMD_SEND_OP, 32'h0, MFP_ACTIVE);
    bit1(od, 1'b0, "push pull");
    sw(EXT_SLEEP_WARN_LIMIT, 8'h05, 1'b1);
    sw(EXT_POWER_OFF_NOTICE, NOTICE_LIVE, 1'b0);
    sw(EXT_POWER_OFF_NOTICE, NOTICE_NONE, 1'b1);
    rd(EXT_POWER_OFF_NOTICE, NOTICE_LIVE);
    sw(EXT_POWER_OFF_NOTICE, NOTICE_QUICK, 1'b0);
    bit1(dat0_oe, 1'b1, "busy on data");
    bit1(dat0, 1'b0, "data level");
    strobe(0);
    bit1(busy, 1'b0, "prep done");
    sw(EXT_POWER_OFF_NOTICE, NOTICE_QUICK, 1'b0);
    idle(22);
    sw(EXT_POWER_OFF_NOTICE, NOTICE_SLOW, 1'b0);
    cmd(6'h0d, 32'h0, MFP_ACTIVE);
    bit1(busy, 1'b0, "busy");
    rd(EXT_POWER_OFF_NOTICE, NOTICE_LIVE);
    sw(EXT_POWER_OFF_NOTICE, NOTICE_SLOW, 1'b0);
    repeat (35) @(negedge core_clk);
    bit1(busy, 1'b1, "slow busy");
    idle(8);
    sw(EXT_POWER_OFF_NOTICE, NOTICE_SLEEP, 1'b0);
    idle(22);
    cmd(CMD_SELECT, 32'h0, MFP_ACTIVE);
    cmd(CMD_SLEEP_AWAKE, 32'h8000, MFP_SLEEP);
    cmd(CMD_SLEEP_AWAKE, 32'h0, MFP_ACTIVE);
    rd(EXT_POWER_OFF_NOTICE, NOTICE_LIVE);
    sw(EXT_POWER_OFF_NOTICE, NOTICE_SLEEP, 1'b0);
    strobe(1);
    bit1(busy, 1'b0, "hpi");
    rd(EXT_POWER_OFF_NOTICE, NOTICE_LIVE);
    rd(EXT_CAPABILITY, 8'h01);
    sw(EXT_MODE_SELECT, MODE_UPDATE, 1'b0);
    bit1(fw_tr, 1'b1, "update");
    rd(EXT_UPDATE_ARG, 8'hc7);
    cmd(6'h19, 32'h0000c7c7, MFP_ACTIVE);
    repeat (3) strobe(2);
    rd(EXT_FW_SECTORS, 8'h03);
    sw(EXT_MODE_SELECT, MODE_NORMAL, 1'b0);
    bit1(fw_tr, 1'b0, "normal");
    cmd(CMD_GO_IDLE, 32'h0, MFP_PRE_IDLE);
    @(negedge core_clk);
    bit1(seen_ins, 1'b1, "install");
    rd(EXT_FW_SECTORS, 8'h00);
    cmd(CMD_SEND_OP, 32'h0, MFP_ACTIVE);
    host.pulse(300);
    bit1(seen_rst, 1'b0, "glitch");
    host.pulse(1000);
    bit1(seen_rst, 1'b1, "hw reset");
    chk(8'(mode_state), 8'(MFP_PRE_IDLE), "mode");
    cmd(CMD_GO_INACTIVE, 32'h0, MFP_INACTIVE);
    cmd(CMD_SEND_OP, 32'h0, MFP_INACTIVE);
    @(posedge core_clk);
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    host.cmd_low(400);
    chk(8'(mode_state), 8'(MFP_BOOT), "mode");
    bit1(od, 1'b1, "open drain");
    cmd(CMD_SEND_OP, 32'h0, MFP_ACTIVE);
    strobe(3);
    chk(8'(mode_state), 8'(MFP_INACTIVE), "mode");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
